// ==== common/tm_map.svh ====
// Behaviour
// RQ1: nonzero channel action lets the waveform drive its pin when direction bit is set.
// RQ2: non-PWM action codes: 00 off, 01 toggle, 10 clear, 11 set on match.
// RQ3: fast PWM: 10 clears on match and sets at bottom, 11 inverse, 01 reserved.
// RQ4: fast PWM with compare equal to TOP and upper bit set ignores the match.
// RQ5: phase PWM: 10 clears on up-count match, sets on down-count match; 11 opposite.
// RQ6: phase PWM with compare equal to TOP: match ignored, set or clear at TOP.
// RQ7: reserved bits of both control registers read as zero.
// RQ8: wave mode is control B bit 3 over control A bits 1:0; 4 and 6 reserved.
// RQ9: normal mode TOP 0xff, clear-on-match TOP compare A; immediate update; overflow at MAX.
// RQ10: phase modes 1 and 5: TOP 0xff or compare A; update at TOP; overflow at BOTTOM.
// RQ11: fast modes 3 and 7: update at BOTTOM; overflow at MAX or TOP.
// RQ12: force strobes act only in non-PWM modes; software writes them zero otherwise.
// RQ13: a force strobe forces a match; output follows current action bits.
// RQ14: forced match sets no flag, never clears the counter; strobes read zero.
// RQ15: clock select: stop, undivided, divide by 8, 32, 64, 128, 256, 1024.
// RQ16: counter register gives direct read and write of the 8-bit count.
// RQ17: a counter write blocks compare matches on the next timer tick.
// RQ18: compare value A is compared with the counter continuously.
// RQ19: match flags set on match; cleared by vector acknowledge or writing one.
// RQ20: compare value B is compared with the counter continuously.
// RQ21: counter steps once per tick; phase modes count up then down, others wrap.
`ifndef TM_MAP_SVH
`define TM_MAP_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define TM_IDX_CTRL_A 8'hb0
`define TM_IDX_CTRL_B 8'hb1
`define TM_IDX_COUNT 8'hb2
`define TM_IDX_CMP_A 8'hb3
`define TM_IDX_CMP_B 8'hb4
`define TM_IDX_FLAGS 8'hb7
`define TM_IDX_PIN_DIR 8'hb8

// ****************************************
// field positions
// ****************************************
`define TM_CA_OUT_A_HI 7
`define TM_CA_OUT_A_LO 6
`define TM_CA_OUT_B_HI 5
`define TM_CA_OUT_B_LO 4
`define TM_CB_FORCE_A 7
`define TM_CB_FORCE_B 6
`define TM_CB_MODE_HIGH 3
`define TM_FLAG_MATCH_B 2
`define TM_FLAG_MATCH_A 1
`define TM_FLAG_OVF 0

// ****************************************
// reset values and limits
// ****************************************
`define TM_RST_BYTE 8'h00
`define TM_MAX 8'hff
`define TM_BOTTOM 8'h00

// ****************************************
// prescaler tap masks
// ****************************************
`define TM_PRE_MASK_8 10'h007
`define TM_PRE_MASK_32 10'h01f
`define TM_PRE_MASK_64 10'h03f
`define TM_PRE_MASK_128 10'h07f
`define TM_PRE_MASK_256 10'h0ff
`define TM_PRE_MASK_1024 10'h3ff

`endif

// ==== common/tm_pkg.sv ====
package tm_pkg;

    // counting direction, gray along up -> down
    typedef enum logic [0:0] {
        TM_UP = 1'b0,
        TM_DOWN = 1'b1
    } tm_dir_e;

    typedef struct packed {
        logic [1:0] out_a_action;
        logic [1:0] out_b_action;
        logic [2:0] wave_mode_sel;
        logic [2:0] clock_select;
    } tm_ctrl_s;

    typedef struct packed {
        logic match_flag_b;
        logic match_flag_a;
        logic overflow;
    } tm_flags_s;

endpackage

// ==== verilog/tm_timer8.sv ====
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "tm_map.svh"

module tm_timer8
    import tm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // vector acknowledge, clears flags
    input wire logic [2:0] vector_ack,
    // waveform pins
    output logic wave_out_a,
    output logic wave_oe_a,
    output logic wave_out_b,
    output logic wave_oe_b,
    // status
    output logic [2:0] flags
);

    // ****************************************
    // state
    // ****************************************
    tm_ctrl_s ctrl_ff, nxt_ctrl;
    tm_flags_s flags_ff, nxt_flags;
    tm_dir_e dir_ff, nxt_dir;
    logic [1:0] pin_dir_ff, nxt_pin_dir;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [7:0] cmp_buf_ff [2];
    logic [7:0] nxt_cmp_buf [2];
    logic [7:0] cmp_eff_ff [2];
    logic [7:0] nxt_cmp_eff [2];
    logic [1:0] force_ff, nxt_force;
    logic block_ff, nxt_block;
    logic [9:0] pre_ff, nxt_pre;
    logic [1:0] wave_ff, nxt_wave;
    logic [1:0] oe_ff, nxt_oe;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;

    // ****************************************
    // decode of mode and bus
    // ****************************************
    logic [2:0] mode;
    logic is_phase, is_fast, is_pwm, top_is_cmp;
    logic [7:0] top;
    logic at_top, at_bot, tick;
    logic [9:0] pre_mask;
    logic acc, wr_en, rd_en;
    logic [7:0] idx;
    logic idx_ok;
    logic [1:0] match;
    logic [1:0] act [2];

    assign mode = ctrl_ff.wave_mode_sel; // see RQ8
    assign is_phase = (mode == 3'd1) || (mode == 3'd5); // see RQ10
    assign is_fast = (mode == 3'd3) || (mode == 3'd7); // see RQ11
    assign is_pwm = is_phase || is_fast;
    assign top_is_cmp = (mode == 3'd2) || (mode == 3'd5) || (mode == 3'd7);
    assign top = top_is_cmp ? cmp_eff_ff[0] : `TM_MAX; // see RQ9
    assign at_top = (cnt_ff == top);
    assign at_bot = (cnt_ff == `TM_BOTTOM);
    assign act[0] = ctrl_ff.out_a_action;
    assign act[1] = ctrl_ff.out_b_action;

    assign acc = psel && penable && pready_ff;
    assign wr_en = acc && pwrite && idx_ok;
    assign rd_en = acc && !pwrite;
    assign idx = paddr[9:2];
    assign idx_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
        ((idx == `TM_IDX_CTRL_A) || (idx == `TM_IDX_CTRL_B) ||
         (idx == `TM_IDX_COUNT) || (idx == `TM_IDX_CMP_A) ||
         (idx == `TM_IDX_CMP_B) || (idx == `TM_IDX_FLAGS) ||
         (idx == `TM_IDX_PIN_DIR));

    // ****************************************
    // prescaler tick
    // ****************************************
    always_comb begin
        case (ctrl_ff.clock_select) // see RQ15
            3'd2: pre_mask = `TM_PRE_MASK_8;
            3'd3: pre_mask = `TM_PRE_MASK_32;
            3'd4: pre_mask = `TM_PRE_MASK_64;
            3'd5: pre_mask = `TM_PRE_MASK_128;
            3'd6: pre_mask = `TM_PRE_MASK_256;
            3'd7: pre_mask = `TM_PRE_MASK_1024;
            default: pre_mask = 10'h000;
        endcase
        nxt_pre = pre_ff + 10'd1;
        tick = (ctrl_ff.clock_select != 3'd0) && ((pre_ff & pre_mask) == pre_mask);
    end

    // ****************************************
    // registers written by software
    // ****************************************
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_pin_dir = pin_dir_ff;
        nxt_force = 2'b00;
        for (int i = 0; i < 2; i++) begin
            nxt_cmp_buf[i] = cmp_buf_ff[i];
        end
        if (wr_en) begin
            if (idx == `TM_IDX_CTRL_A) begin
                nxt_ctrl.out_a_action = pwdata[`TM_CA_OUT_A_HI:`TM_CA_OUT_A_LO];
                nxt_ctrl.out_b_action = pwdata[`TM_CA_OUT_B_HI:`TM_CA_OUT_B_LO];
                nxt_ctrl.wave_mode_sel[1:0] = pwdata[1:0]; // see RQ8
            end else if (idx == `TM_IDX_CTRL_B) begin
                nxt_ctrl.wave_mode_sel[2] = pwdata[`TM_CB_MODE_HIGH]; // see RQ8
                nxt_ctrl.clock_select = pwdata[2:0];
                if (!is_pwm) begin
                    nxt_force[0] = pwdata[`TM_CB_FORCE_A]; // see RQ12
                    nxt_force[1] = pwdata[`TM_CB_FORCE_B]; // see RQ12
                end
            end else if (idx == `TM_IDX_CMP_A) begin
                nxt_cmp_buf[0] = pwdata[7:0];
            end else if (idx == `TM_IDX_CMP_B) begin
                nxt_cmp_buf[1] = pwdata[7:0];
            end else if (idx == `TM_IDX_PIN_DIR) begin
                nxt_pin_dir = pwdata[1:0];
            end
        end
    end

    // ****************************************
    // counter and direction
    // ****************************************
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        nxt_block = block_ff;
        if (tick) begin
            nxt_block = 1'b0;
            if (is_phase) begin // see RQ21
                if (dir_ff == TM_UP) begin
                    if (at_top) begin
                        nxt_dir = TM_DOWN;
                        nxt_cnt = cnt_ff - 8'd1;
                    end else begin
                        nxt_cnt = cnt_ff + 8'd1;
                    end
                end else begin
                    if (at_bot) begin
                        nxt_dir = TM_UP;
                        nxt_cnt = cnt_ff + 8'd1;
                    end else begin
                        nxt_cnt = cnt_ff - 8'd1;
                    end
                end
            end else begin
                nxt_dir = TM_UP;
                nxt_cnt = at_top ? `TM_BOTTOM : cnt_ff + 8'd1; // see RQ21
            end
        end
        if (wr_en && (idx == `TM_IDX_COUNT)) begin
            nxt_cnt = pwdata[7:0]; // see RQ16
            nxt_block = 1'b1; // see RQ17
        end
    end

    // ****************************************
    // compare units and buffered compare values
    // ****************************************
    logic upd;
    always_comb begin
        if (!is_pwm) begin
            upd = 1'b1; // see RQ9
        end else if (is_phase) begin
            upd = tick && at_top && (dir_ff == TM_UP); // see RQ10
        end else begin
            upd = tick && at_top; // see RQ11
        end
        for (int i = 0; i < 2; i++) begin
            nxt_cmp_eff[i] = upd ? nxt_cmp_buf[i] : cmp_eff_ff[i];
            match[i] = tick && !block_ff && (cnt_ff == cmp_eff_ff[i]); // see RQ18 see RQ20 see RQ17
        end
    end

    // ****************************************
    // flags
    // ****************************************
    logic ovf;
    always_comb begin
        if (is_phase) begin
            ovf = tick && at_bot && (dir_ff == TM_DOWN); // see RQ10
        end else if (mode == 3'd7) begin
            ovf = tick && at_top; // see RQ11
        end else begin
            ovf = tick && (cnt_ff == `TM_MAX); // see RQ9 see RQ11
        end
        nxt_flags = flags_ff;
        if (vector_ack[0] || (wr_en && (idx == `TM_IDX_FLAGS) && pwdata[`TM_FLAG_OVF])) begin
            nxt_flags.overflow = 1'b0;
        end
        if (vector_ack[1] ||
            (wr_en && (idx == `TM_IDX_FLAGS) && pwdata[`TM_FLAG_MATCH_A])) begin
            nxt_flags.match_flag_a = 1'b0; // see RQ19
        end
        if (vector_ack[2] ||
            (wr_en && (idx == `TM_IDX_FLAGS) && pwdata[`TM_FLAG_MATCH_B])) begin
            nxt_flags.match_flag_b = 1'b0; // see RQ19
        end
        // set wins over clear; forced matches never reach here
        if (ovf) begin
            nxt_flags.overflow = 1'b1;
        end
        if (match[0]) begin
            nxt_flags.match_flag_a = 1'b1; // see RQ19 see RQ14
        end
        if (match[1]) begin
            nxt_flags.match_flag_b = 1'b1; // see RQ19 see RQ14
        end
    end

    // ****************************************
    // waveform units, one per channel
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_wave
            logic cmp_top;
            logic a_toggle;
            assign cmp_top = (cmp_eff_ff[ch] == top);
            // channel a only: code 01 toggles in pwm when mode high bit set
            assign a_toggle = (ch == 0) && (act[ch] == 2'b01) && mode[2];
            always_comb begin
                nxt_wave[ch] = wave_ff[ch];
                if (!is_pwm) begin
                    if (match[ch] || force_ff[ch]) begin // see RQ13
                        case (act[ch]) // see RQ2
                            2'b01: nxt_wave[ch] = !wave_ff[ch];
                            2'b10: nxt_wave[ch] = 1'b0;
                            2'b11: nxt_wave[ch] = 1'b1;
                            default: nxt_wave[ch] = wave_ff[ch];
                        endcase
                    end
                end else if (a_toggle) begin
                    if (match[ch]) begin
                        nxt_wave[ch] = !wave_ff[ch];
                    end
                end else if (act[ch][1]) begin
                    if (is_fast) begin
                        if (tick && at_top) begin
                            nxt_wave[ch] = !act[ch][0]; // see RQ3
                        end else if (match[ch] && !cmp_top) begin
                            nxt_wave[ch] = act[ch][0]; // see RQ3 see RQ4
                        end
                    end else if (cmp_top) begin
                        if (tick && at_top && (dir_ff == TM_UP)) begin
                            nxt_wave[ch] = !act[ch][0]; // see RQ6
                        end
                    end else if (match[ch]) begin
                        nxt_wave[ch] = (dir_ff == TM_UP) ? act[ch][0] : !act[ch][0]; // see RQ5
                    end
                end
                nxt_oe[ch] = (act[ch] != 2'b00) && pin_dir_ff[ch]; // see RQ1
            end
        end
    endgenerate

    // ****************************************
    // apb answer, zero wait states
    // ****************************************
    always_comb begin
        nxt_pready = psel && !penable;
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (psel && !penable) begin
            nxt_pslverr = !idx_ok;
            if (!pwrite && idx_ok) begin
                if (idx == `TM_IDX_CTRL_A) begin
                    nxt_prdata[7:0] = {ctrl_ff.out_a_action, ctrl_ff.out_b_action,
                        2'b00, ctrl_ff.wave_mode_sel[1:0]}; // see RQ7
                end else if (idx == `TM_IDX_CTRL_B) begin
                    nxt_prdata[7:0] = {4'h0, ctrl_ff.wave_mode_sel[2],
                        ctrl_ff.clock_select}; // see RQ7 see RQ14
                end else if (idx == `TM_IDX_COUNT) begin
                    nxt_prdata[7:0] = cnt_ff; // see RQ16
                end else if (idx == `TM_IDX_CMP_A) begin
                    nxt_prdata[7:0] = cmp_buf_ff[0];
                end else if (idx == `TM_IDX_CMP_B) begin
                    nxt_prdata[7:0] = cmp_buf_ff[1];
                end else if (idx == `TM_IDX_FLAGS) begin
                    nxt_prdata[2:0] = flags_ff;
                end else if (idx == `TM_IDX_PIN_DIR) begin
                    nxt_prdata[1:0] = pin_dir_ff;
                end
            end
        end else if (psel && penable && !rd_en) begin
            nxt_prdata = prdata_ff;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff <= '0;
            flags_ff <= '0;
            dir_ff <= TM_UP;
            pin_dir_ff <= 2'b00;
            cnt_ff <= `TM_RST_BYTE;
            cmp_buf_ff[0] <= `TM_RST_BYTE;
            cmp_buf_ff[1] <= `TM_RST_BYTE;
            cmp_eff_ff[0] <= `TM_RST_BYTE;
            cmp_eff_ff[1] <= `TM_RST_BYTE;
            force_ff <= 2'b00;
            block_ff <= 1'b0;
            pre_ff <= 10'h000;
            wave_ff <= 2'b00;
            oe_ff <= 2'b00;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            flags_ff <= nxt_flags;
            dir_ff <= nxt_dir;
            pin_dir_ff <= nxt_pin_dir;
            cnt_ff <= nxt_cnt;
            cmp_buf_ff[0] <= nxt_cmp_buf[0];
            cmp_buf_ff[1] <= nxt_cmp_buf[1];
            cmp_eff_ff[0] <= nxt_cmp_eff[0];
            cmp_eff_ff[1] <= nxt_cmp_eff[1];
            force_ff <= nxt_force;
            block_ff <= nxt_block;
            pre_ff <= nxt_pre;
            wave_ff <= nxt_wave;
            oe_ff <= nxt_oe;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign wave_out_a = wave_ff[0];
    assign wave_out_b = wave_ff[1];
    assign wave_oe_a = oe_ff[0];
    assign wave_oe_b = oe_ff[1];
    assign flags = flags_ff;

endmodule

`default_nettype wire

// ==== bench/tm_timer8_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tm_map.svh"

module tm_timer8_props
    import tm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // flags and pins
    input wire logic [2:0] vector_ack,
    input wire logic wave_out_a,
    input wire logic wave_oe_a,
    input wire logic wave_out_b,
    input wire logic wave_oe_b,
    input wire logic [2:0] flags
);
    // ****************************************
    // shadow of the clock select field
    // ****************************************
    logic acc;
    logic [2:0] cs_ff;
    logic [2:0] nxt_cs;
    assign acc = psel && penable && pready;
    always_comb begin
        nxt_cs = cs_ff;
        if (acc && pwrite && !pslverr && paddr[9:2] == `TM_IDX_CTRL_B) begin
            nxt_cs = pwdata[2:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_ff <= 3'h0;
        end else begin
            cs_ff <= nxt_cs;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence setup_s(logic [7:0] i);
        psel && !penable && paddr == {2'b00, i, 2'b00};
    endsequence
    sequence ctrl_a_quiet_s;
        acc && pwrite && !pslverr && paddr[9:2] == `TM_IDX_CTRL_A && pwdata[5:4] == 2'b00;
    endsequence

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no zero-wait answer");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("answer without setup");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    unaligned_err_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("unaligned access accepted");
    map_ok_a: assert property (setup_s(`TM_IDX_CTRL_A) |=> !pslverr)
        else $error("mapped access refused");
    ctrl_a_rsvd_a: assert property (setup_s(`TM_IDX_CTRL_A) ##0 !pwrite |=> prdata[3:2] == 2'b00)
        else $error("control a reserved bits set");
    ctrl_b_rsvd_a: assert property (setup_s(`TM_IDX_CTRL_B) ##0 !pwrite |=> prdata[7:4] == 4'h0)
        else $error("control b upper bits set");
    oe_off_a: assert property (ctrl_a_quiet_s |-> ##2 !wave_oe_b)
        else $error("pin driven with no action");
    flags_hold_a: assert property (cs_ff == 3'h0 && !acc && vector_ack == 3'h0 |=> $stable(flags))
        else $error("flags moved while stopped");
    ack_clear_a: assert property (cs_ff == 3'h0 && vector_ack[0] |=> !flags[0])
        else $error("overflow not cleared by ack");
endmodule

bind tm_timer8 tm_timer8_props u_props (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vector_ack(vector_ack), .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a),
    .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b), .flags(flags)
);
`default_nettype wire

// ==== bench/tm_timer8_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tm_map.svh"

module tm_timer8_tb_top import tm_pkg::*; ();
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [2:0] vector_ack, flags;
    logic wave_out_a, wave_oe_a, wave_out_b, wave_oe_b, re;
    logic [1:0] ua = 2'b00;
    int fail_count, n_checks;
    logic [1:0] act [5] = '{2'b01, 2'b01, 2'b11, 2'b10, 2'b11};
    logic lvl [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    tm_timer8 DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vector_ack(vector_ack), .wave_out_a(wave_out_a),
        .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b), .flags(flags));

    // ****************************************
    // tasks
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, ua};
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(nm, exp, rq);
    endtask
    task automatic wflag(input int b);
        int n;
        n = 0;
        while (flags[b] !== 1'b1 && n < 600) begin
            @(posedge sys_clk);
            n++;
        end
        chk("flag_wait", 32'h1, {31'h0, n < 600});
        if (n >= 600) close_out();
    endtask
    task automatic meas(input logic [7:0] ca, input int lo, input int hi);
        int h;
        h = 0;
        wr(`TM_IDX_CTRL_A, ca);
        cyc(600);
        repeat (512) begin
            @(posedge sys_clk);
            h += (wave_out_b === 1'b1) ? 1 : 0;
        end
        chk("duty", 32'h1, {31'h0, h >= lo && h <= hi});
    endtask

    // ****************************************
    // clock and tests
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        vector_ack = 3'h0;
        fail_count = 0;
        n_checks = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdc("ctrl_a", `TM_IDX_CTRL_A, 32'h00000000);
        rdc("ctrl_b", `TM_IDX_CTRL_B, 32'h00000000);
        rdc("count", `TM_IDX_COUNT, 32'h00000000);
        wr(`TM_IDX_CTRL_A, 8'hff);
        rdc("ctrl_a", `TM_IDX_CTRL_A, 32'h000000f3);
        wr(`TM_IDX_CTRL_B, 8'hc8);
        rdc("ctrl_b", `TM_IDX_CTRL_B, 32'h00000008);
        chk("oe_b", 32'h0, {31'h0, wave_oe_b});
        apb(1'b0, 8'h20, 8'h00);
        chk("slverr", 32'h1, {31'h0, re});
        chk("unmapped", 32'h0, rq);
        ua = 2'b01;
        apb(1'b0, `TM_IDX_CTRL_A, 8'h00);
        ua = 2'b00;
        chk("unaligned", 32'h1, {31'h0, re});
        chk("refused", 32'h0, rq);
        wr(`TM_IDX_CTRL_A, 8'h00);
        wr(`TM_IDX_CTRL_B, 8'h00);
        wr(`TM_IDX_COUNT, 8'h5a);
        rdc("count", `TM_IDX_COUNT, 32'h0000005a);
        wr(`TM_IDX_CMP_A, 8'ha5);
        rdc("cmp_a", `TM_IDX_CMP_A, 32'h000000a5);
        $display("test registers done");
        wr(`TM_IDX_PIN_DIR, 8'h03);
        for (int i = 0; i < 5; i++) begin
            wr(`TM_IDX_CTRL_A, {2'b00, act[i], 4'h0});
            wr(`TM_IDX_CTRL_B, 8'h40);
            cyc(1);
            chk("out_b", {31'h0, lvl[i]}, {31'h0, wave_out_b});
            chk("oe_b", 32'h1, {31'h0, wave_oe_b});
        end
        wr(`TM_IDX_CTRL_A, 8'hc0);
        wr(`TM_IDX_CTRL_B, 8'h80);
        cyc(1);
        chk("out_a", 32'h1, {31'h0, wave_out_a});
        chk("oe_a", 32'h1, {31'h0, wave_oe_a});
        rdc("flags", `TM_IDX_FLAGS, 32'h00000000);
        rdc("count", `TM_IDX_COUNT, 32'h0000005a);
        wr(`TM_IDX_CTRL_A, 8'h23);
        wr(`TM_IDX_CTRL_B, 8'h40);
        cyc(1);
        chk("out_b", 32'h1, {31'h0, wave_out_b});
        wr(`TM_IDX_CTRL_A, 8'h00);
        cyc(1);
        chk("oe_b", 32'h0, {31'h0, wave_oe_b});
        $display("test force done");
        wr(`TM_IDX_CMP_A, 8'h20);
        wr(`TM_IDX_COUNT, 8'h20);
        wr(`TM_IDX_CTRL_B, 8'h01);
        cyc(3);
        wr(`TM_IDX_CTRL_B, 8'h00);
        rdc("flags", `TM_IDX_FLAGS, 32'h00000000);
        wr(`TM_IDX_COUNT, 8'hfd);
        wr(`TM_IDX_CTRL_B, 8'h01);
        wflag(0);
        wr(`TM_IDX_CTRL_B, 8'h00);
        rdc("flags", `TM_IDX_FLAGS, 32'h00000005);
        apb(1'b0, `TM_IDX_COUNT, 8'h00);
        chk("wrap", 32'h1, {31'h0, rq < 32'h10});
        wr(`TM_IDX_FLAGS, 8'h07);
        rdc("flags", `TM_IDX_FLAGS, 32'h00000000);
        wr(`TM_IDX_COUNT, 8'hfd);
        wr(`TM_IDX_CTRL_B, 8'h01);
        wflag(0);
        wr(`TM_IDX_CTRL_B, 8'h00);
        vector_ack <= 3'h7;
        @(posedge sys_clk);
        vector_ack <= 3'h0;
        cyc(1);
        chk("flags", 32'h0, {29'h0, flags});
        $display("test normal done");
        for (int k = 2; k < 8; k++) begin
            wr(`TM_IDX_COUNT, 8'h00);
            wr(`TM_IDX_CTRL_B, k[7:0]);
            cyc(4 * dv[k]);
            wr(`TM_IDX_CTRL_B, 8'h00);
            apb(1'b0, `TM_IDX_COUNT, 8'h00);
            chk("ticks", 32'h1, {31'h0, rq >= 32'h3 && rq <= 32'h5});
        end
        $display("test prescale done");
        wr(`TM_IDX_CMP_A, 8'h10);
        wr(`TM_IDX_COUNT, 8'h00);
        wr(`TM_IDX_CTRL_A, 8'h02);
        wr(`TM_IDX_FLAGS, 8'h07);
        wr(`TM_IDX_CTRL_B, 8'h01);
        cyc(60);
        wr(`TM_IDX_CTRL_B, 8'h00);
        apb(1'b0, `TM_IDX_COUNT, 8'h00);
        chk("ctc_top", 32'h1, {31'h0, rq <= 32'h10});
        apb(1'b0, `TM_IDX_FLAGS, 8'h00);
        chk("match_a", 32'h2, rq & 32'h2);
        $display("test ctc done");
        wr(`TM_IDX_CMP_B, 8'h80);
        wr(`TM_IDX_CTRL_B, 8'h01);
        meas(8'h23, 252, 264);
        meas(8'h33, 248, 260);
        wr(`TM_IDX_CMP_B, 8'hff);
        meas(8'h23, 512, 512);
        wr(`TM_IDX_CMP_B, 8'h40);
        meas(8'h21, 120, 136);
        meas(8'h31, 376, 392);
        wr(`TM_IDX_PIN_DIR, 8'h01);
        cyc(1);
        chk("oe_b", 32'h0, {31'h0, wave_oe_b});
        $display("test pwm done");
        close_out();
    end
endmodule
`default_nettype wire
